/* File: rtl/adcsq_pkg.sv */
// Purpose: shared constants and types of the two-unit conversion sequencer
// Assumes: one conversion state equals one period of clk_sys_i
// Notes: byte-wide register port, 32 byte addresses, bit 4 of the address selects the unit
package adcsq_pkg;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;
    localparam int RES_W = 10;
    localparam int N_UNITS = 2;
    localparam int N_CH = 4;
    // register offsets inside one unit; results take two bytes each, upper byte first
    localparam logic [3:0] OFS_RESULT_A = 4'h0;
    localparam logic [3:0] OFS_CTRL_STATUS = 4'h8;
    localparam logic [3:0] OFS_TRIGGER_CTRL = 4'h9;
    localparam int UNIT_SEL_BIT = 4;
    // control/status fields
    localparam int CSR_END_FLAG_BIT = 7;
    localparam int CSR_IRQ_EN_BIT = 6;
    localparam int CSR_START_BIT = 5;
    localparam int CSR_SCAN_BIT = 4;
    localparam int CSR_SPEED_BIT = 3;
    localparam int CSR_CH_HI_BIT = 1;
    localparam int CSR_CH_LO_BIT = 0;
    localparam logic [7:0] CSR_RESET = 8'h02;
    localparam logic [7:0] CSR_WRITE_MASK = 8'h7b;
    // trigger control fields
    localparam int TRG_EN_BIT = 7;
    localparam logic [7:0] TRG_RSVD_ONES = 8'h7f;
    localparam logic TRG_EN_RESET = 1'b0;
    // timing, in states, then in clock cycles
    localparam int STATE_NS = 10;
    localparam int CLK_NS = 10;
    localparam int START_DELAY_SLOW_ST = 10;
    localparam int START_DELAY_FAST_ST = 6;
    localparam int PERIOD_SLOW_ST = 256;
    localparam int PERIOD_FAST_ST = 128;
    localparam int SAMPLE_SLOW_ST = 64;
    localparam int SAMPLE_FAST_ST = 32;
    localparam int BIT_STEP_SLOW_ST = 16;
    localparam int BIT_STEP_FAST_ST = 8;
    localparam logic [8:0] START_DELAY_SLOW_CYC = 9'((START_DELAY_SLOW_ST * STATE_NS) / CLK_NS);
    localparam logic [8:0] START_DELAY_FAST_CYC = 9'((START_DELAY_FAST_ST * STATE_NS) / CLK_NS);
    localparam logic [8:0] PERIOD_SLOW_CYC = 9'((PERIOD_SLOW_ST * STATE_NS) / CLK_NS);
    localparam logic [8:0] PERIOD_FAST_CYC = 9'((PERIOD_FAST_ST * STATE_NS) / CLK_NS);
    localparam logic [8:0] SAMPLE_SLOW_CYC = 9'((SAMPLE_SLOW_ST * STATE_NS) / CLK_NS);
    localparam logic [8:0] SAMPLE_FAST_CYC = 9'((SAMPLE_FAST_ST * STATE_NS) / CLK_NS);
    localparam logic [8:0] BIT_STEP_SLOW_CYC = 9'((BIT_STEP_SLOW_ST * STATE_NS) / CLK_NS);
    localparam logic [8:0] BIT_STEP_FAST_CYC = 9'((BIT_STEP_FAST_ST * STATE_NS) / CLK_NS);
    localparam logic [3:0] SAR_STEPS = 4'ha;

    typedef enum logic [1:0] {PH_IDLE, PH_DELAY, PH_CONV} adcsq_phase_t;
endpackage

/* File: rtl/adcsq_top.sv */
// Purpose: sequencer, timing and registers of a two-unit 10-bit approximation converter
// Assumes: all inputs synchronous to clk_sys_i; comparator output valid one cycle after the code
// Notes: unit 0 serves inputs 0-3, unit 1 inputs 4-7; analog front end lives outside
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// RULE1 - resolve each sample to 10 bits by approximation
// RULE2 - single mode converts one channel on start
// RULE3 - start reads 1, cleared at single completion
// RULE4 - completion sets end flag, interrupt if enabled
// RULE5 - flag clears by 0 write after reading 1
// RULE6 - software stops before changing mode or channel
// RULE7 - result lands in that channel's own register
// RULE8 - scan begins at group's first channel
// RULE9 - next scan channel starts with no gap
// RULE10 - scan end sets flag, restarts at first
// RULE11 - clearing start halts; setting restarts from first
// RULE12 - sampling follows a start delay
// RULE13 - first conversion at most 266 or 134
// RULE14 - later conversions fixed 256 or 128 states
// RULE15 - enabled trigger edge sets the start bit
// RULE16 - triggered start behaves like software start
// RULE17 - unit 0 feeds transfer controller, unit 1 DMA
// RULE18 - transfer controller access clears unit 0 flag
// RULE19 - DMA access clears unit 1 flag
// RULE20 - channel bits pick one, or first 1-4
// RULE21 - upper byte read latches lower byte
// RULE22 - both units' trigger enables are ORed
// RULE23 - abandoned conversion leaves result and flag
module adcsq_top (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic [4:0] bus_addr_i,
    input wire logic [7:0] bus_wdata_i,
    input wire logic bus_wr_i,
    input wire logic bus_rd_i,
    output logic [7:0] bus_rdata_o,
    input wire logic xfer_ctrl_access_i,
    input wire logic dma_access_i,
    input wire logic ext_trigger_pin_n_i,
    input wire logic timer_trigger_i,
    input wire logic [1:0] cmp_i,
    output logic [1:0] sample_o,
    output logic [1:0][2:0] chan_o,
    output logic [1:0][9:0] dac_code_o,
    output logic unit0_end_irq_o,
    output logic unit1_end_irq_o,
    output logic xfer_ctrl_req_o,
    output logic dma_req_o
);
    typedef struct packed {
        adcsq_pkg::adcsq_phase_t [1:0] phase;
        logic [1:0][7:0] csr;
        logic [1:0] trigger_enable;
        logic [1:0] flag_armed;
        logic [1:0][8:0] cnt;
        logic [1:0][1:0] ch_idx;
        logic [1:0][9:0] sar;
        logic [1:0][3:0] step;
        logic [1:0][3:0][9:0] result;
        logic [1:0][7:0] temp;
        logic [1:0] irq;
        logic [1:0] sample;
        logic [1:0][2:0] chan;
        logic trig_pin_prev;
        logic [7:0] rdata;
    } adcsq_state_t;

    adcsq_state_t q;
    adcsq_state_t d;

    logic [1:0][8:0] per_w;
    logic [1:0][8:0] spl_w;
    logic [1:0][8:0] stp_w;
    logic [1:0][8:0] dly_w;
    logic [1:0] done_w;
    logic [1:0] last_w;
    logic [1:0] unit_hit_w;
    logic [1:0] auto_clr_w;
    logic trig_evt_w;

    // pin is active low: its last edge is the release back to high
    assign trig_evt_w = (ext_trigger_pin_n_i && !q.trig_pin_prev) || timer_trigger_i; // RULE15

    genvar gu;
    generate
        for (gu = 0; gu < adcsq_pkg::N_UNITS; gu++)
        begin : g_unit
            logic slow;
            logic scan;
            assign slow = !q.csr[gu][adcsq_pkg::CSR_SPEED_BIT];
            assign scan = q.csr[gu][adcsq_pkg::CSR_SCAN_BIT];
            assign per_w[gu] = slow ? adcsq_pkg::PERIOD_SLOW_CYC
                                    : adcsq_pkg::PERIOD_FAST_CYC; // RULE14
            assign spl_w[gu] = slow ? adcsq_pkg::SAMPLE_SLOW_CYC : adcsq_pkg::SAMPLE_FAST_CYC;
            assign stp_w[gu] = slow ? adcsq_pkg::BIT_STEP_SLOW_CYC : adcsq_pkg::BIT_STEP_FAST_CYC;
            assign dly_w[gu] = slow ? adcsq_pkg::START_DELAY_SLOW_CYC
                                    : adcsq_pkg::START_DELAY_FAST_CYC; // RULE12
            assign done_w[gu] = (q.phase[gu] == adcsq_pkg::PH_CONV)
                                && (q.cnt[gu] == per_w[gu] - 9'h001);
            // scan length is channel code plus one
            assign last_w[gu] = !scan || (q.ch_idx[gu] == q.csr[gu][1:0]); // RULE20 RULE10
            assign unit_hit_w[gu] = (bus_wr_i || bus_rd_i)
                                    && (bus_addr_i[adcsq_pkg::UNIT_SEL_BIT] == 1'(gu));
            // each unit's request may only wake its own controller
            if (gu == 0)
            begin : g_xfer
                // flag clears on the access itself, so the controller needs no extra write
                assign auto_clr_w[gu] = unit_hit_w[gu] && xfer_ctrl_access_i
                                        && q.irq[gu]; // RULE18 RULE17
            end
            else
            begin : g_dma
                assign auto_clr_w[gu] = unit_hit_w[gu] && dma_access_i
                                        && q.irq[gu]; // RULE19 RULE17
            end

            a_single_start_clr: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE3
                done_w[gu] && !scan && !(bus_wr_i && unit_hit_w[gu])
                |=> !q.csr[gu][adcsq_pkg::CSR_START_BIT] && q.phase[gu] == adcsq_pkg::PH_IDLE)
                else $error("single conversion did not clear start");
            a_end_flag_set: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE4
                done_w[gu] && last_w[gu] && !(bus_wr_i && unit_hit_w[gu])
                |=> q.csr[gu][adcsq_pkg::CSR_END_FLAG_BIT]
                ##1 (q.irq[gu] == q.csr[gu][adcsq_pkg::CSR_IRQ_EN_BIT]))
                else $error("end flag or interrupt missing after completion");
            a_flag_hold_unread: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE5
                bus_wr_i && unit_hit_w[gu] && bus_addr_i[3:0] == adcsq_pkg::OFS_CTRL_STATUS
                && q.csr[gu][adcsq_pkg::CSR_END_FLAG_BIT] && !q.flag_armed[gu] && !auto_clr_w[gu]
                |=> q.csr[gu][adcsq_pkg::CSR_END_FLAG_BIT])
                else $error("end flag cleared without prior read");
            a_flag_clr_armed: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE5
                bus_wr_i && unit_hit_w[gu] && bus_addr_i[3:0] == adcsq_pkg::OFS_CTRL_STATUS
                && !bus_wdata_i[adcsq_pkg::CSR_END_FLAG_BIT] && q.flag_armed[gu] && !done_w[gu]
                |=> !q.csr[gu][adcsq_pkg::CSR_END_FLAG_BIT])
                else $error("armed end flag not cleared by zero write");
            a_result_store: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE7
                done_w[gu] && q.csr[gu][adcsq_pkg::CSR_START_BIT] && !(bus_wr_i && unit_hit_w[gu])
                |=> q.result[gu][$past(q.chan[gu][1:0])] == $past(q.sar[gu]))
                else $error("result not stored in its channel register");
            a_scan_no_gap: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE9
                done_w[gu] && scan && !(bus_wr_i && unit_hit_w[gu])
                |=> q.phase[gu] == adcsq_pkg::PH_CONV && q.cnt[gu] == 9'h000 && q.sample[gu])
                else $error("gap between scan conversions");
            a_scan_first_ch: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE8
                q.phase[gu] == adcsq_pkg::PH_DELAY && scan |-> q.chan[gu] == 3'(gu * 4))
                else $error("scan did not begin at group's first input");
            a_first_conv_max: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE13
                $rose(q.phase[gu] == adcsq_pkg::PH_DELAY) && slow
                ##1 (q.csr[gu][adcsq_pkg::CSR_START_BIT] && slow)[*8]
                |-> ##[1:258] done_w[gu])
                else $error("first conversion too long");
            a_abort_keeps: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE23
                q.phase[gu] == adcsq_pkg::PH_CONV && bus_wr_i && unit_hit_w[gu]
                && bus_addr_i[3:0] == adcsq_pkg::OFS_CTRL_STATUS
                && !bus_wdata_i[adcsq_pkg::CSR_START_BIT]
                |=> q.phase[gu] == adcsq_pkg::PH_IDLE && q.result[gu] == $past(q.result[gu]))
                else $error("aborted conversion changed a result");
            a_trigger_start: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE15
                trig_evt_w && (q.trigger_enable != 2'b00) && !(bus_wr_i && unit_hit_w[gu])
                |=> q.csr[gu][adcsq_pkg::CSR_START_BIT])
                else $error("enabled trigger did not set start");
            a_auto_clear: assert property (@(posedge clk_sys_i) // RULE18 RULE19
                disable iff (srst_i)
                auto_clr_w[gu] && !done_w[gu] |=> !q.csr[gu][adcsq_pkg::CSR_END_FLAG_BIT])
                else $error("controller access did not clear end flag");
            a_temp_latch: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE21
                bus_rd_i && unit_hit_w[gu] && bus_addr_i[3] == 1'b0 && bus_addr_i[0] == 1'b0
                |=> q.temp[gu] == {$past(q.result[gu][bus_addr_i[2:1]][1:0]), 6'h00})
                else $error("lower byte not latched on upper read");
            a_delay_length: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE12
                $rose(q.phase[gu] == adcsq_pkg::PH_CONV)
                |-> $past(q.phase[gu] == adcsq_pkg::PH_DELAY)
                && $past(q.cnt[gu]) == dly_w[gu] - 9'h001)
                else $error("start delay length wrong");
            c_scan_wrap: cover property (@(posedge clk_sys_i) disable iff (srst_i)
                done_w[gu] && scan && last_w[gu] && q.csr[gu][1:0] == 2'b11);
            c_abort: cover property (@(posedge clk_sys_i) disable iff (srst_i)
                q.phase[gu] == adcsq_pkg::PH_CONV && !d.csr[gu][adcsq_pkg::CSR_START_BIT]);
            c_trig_run: cover property (@(posedge clk_sys_i) disable iff (srst_i)
                trig_evt_w && q.trigger_enable[gu] ##[1:300] done_w[gu]);
            c_single_done: cover property (@(posedge clk_sys_i) disable iff (srst_i)
                done_w[gu] && !scan);
            c_auto_clr: cover property (@(posedge clk_sys_i) disable iff (srst_i)
                auto_clr_w[gu]);
        end
    endgenerate

    always_comb
    begin
        logic [3:0] off;
        logic [8:0] rel;
        logic start_now;
        logic [1:0] ch;
        off = bus_addr_i[3:0];
        rel = 9'h000;
        start_now = 1'b0;
        ch = 2'b00;
        d = q;
        d.trig_pin_prev = ext_trigger_pin_n_i;
        d.rdata = 8'h00;
        for (int u = 0; u < adcsq_pkg::N_UNITS; u++)
        begin
            // read side effects
            if (bus_rd_i && unit_hit_w[u])
            begin
                if (off == adcsq_pkg::OFS_CTRL_STATUS)
                begin
                    d.rdata = q.csr[u];
                    d.flag_armed[u] = q.csr[u][adcsq_pkg::CSR_END_FLAG_BIT]; // RULE5
                end
                else if (off == adcsq_pkg::OFS_TRIGGER_CTRL)
                begin
                    d.rdata = adcsq_pkg::TRG_RSVD_ONES;
                    d.rdata[adcsq_pkg::TRG_EN_BIT] = q.trigger_enable[u];
                end
                else if (off < adcsq_pkg::OFS_CTRL_STATUS)
                begin
                    // left aligned result: upper byte holds bits 9..2
                    if (!off[0])
                    begin
                        d.rdata = q.result[u][off[2:1]][9:2];
                        d.temp[u] = {q.result[u][off[2:1]][1:0], 6'h00}; // RULE21
                    end
                    else
                    begin
                        d.rdata = q.temp[u]; // RULE21
                    end
                end
            end
            // register writes
            if (bus_wr_i && unit_hit_w[u])
            begin
                if (off == adcsq_pkg::OFS_CTRL_STATUS)
                begin
                    // mode and channel taken as written; software keeps them still while running
                    d.csr[u] = (bus_wdata_i & adcsq_pkg::CSR_WRITE_MASK)
                               | (q.csr[u] & ~adcsq_pkg::CSR_WRITE_MASK); // RULE6
                    if (!bus_wdata_i[adcsq_pkg::CSR_END_FLAG_BIT] && q.flag_armed[u])
                    begin
                        d.csr[u][adcsq_pkg::CSR_END_FLAG_BIT] = 1'b0; // RULE5
                    end
                    d.flag_armed[u] = 1'b0;
                end
                else if (off == adcsq_pkg::OFS_TRIGGER_CTRL)
                begin
                    d.trigger_enable[u] = bus_wdata_i[adcsq_pkg::TRG_EN_BIT];
                end
            end
            if (auto_clr_w[u])
            begin
                d.csr[u][adcsq_pkg::CSR_END_FLAG_BIT] = 1'b0; // RULE18 RULE19
            end
            // shared trigger wakes both units when either enables it
            if (trig_evt_w && (q.trigger_enable[0] || q.trigger_enable[1]))
            begin
                d.csr[u][adcsq_pkg::CSR_START_BIT] = 1'b1; // RULE22 RULE16
            end
            start_now = d.csr[u][adcsq_pkg::CSR_START_BIT];
            // sequencer
            if (!start_now)
            begin
                d.phase[u] = adcsq_pkg::PH_IDLE; // RULE11 RULE23
                d.sample[u] = 1'b0;
            end
            else
            begin
                case (q.phase[u])
                    adcsq_pkg::PH_IDLE:
                    begin
                        d.phase[u] = adcsq_pkg::PH_DELAY; // RULE2 RULE16
                        d.cnt[u] = 9'h000;
                        d.ch_idx[u] = 2'b00; // RULE8 RULE11
                    end
                    adcsq_pkg::PH_DELAY:
                    begin
                        d.cnt[u] = q.cnt[u] + 9'h001;
                        if (q.cnt[u] == dly_w[u] - 9'h001)
                        begin
                            d.phase[u] = adcsq_pkg::PH_CONV; // RULE12 RULE13
                            d.cnt[u] = 9'h000;
                            d.sar[u] = 10'h000;
                            d.step[u] = 4'h0;
                            d.sample[u] = 1'b1;
                        end
                    end
                    adcsq_pkg::PH_CONV:
                    begin
                        d.cnt[u] = q.cnt[u] + 9'h001;
                        rel = q.cnt[u] - spl_w[u];
                        if (q.cnt[u] == spl_w[u] - 9'h001)
                        begin
                            d.sample[u] = 1'b0;
                        end
                        // comparator answers the trial bit set one step earlier
                        if (q.cnt[u] >= spl_w[u] && (rel & (stp_w[u] - 9'h001)) == 9'h000
                            && q.step[u] <= adcsq_pkg::SAR_STEPS)
                        begin
                            if (q.step[u] != 4'h0 && !cmp_i[u])
                            begin
                                d.sar[u][4'ha - q.step[u]] = 1'b0; // RULE1
                            end
                            if (q.step[u] != adcsq_pkg::SAR_STEPS)
                            begin
                                d.sar[u][4'h9 - q.step[u]] = 1'b1; // RULE1
                            end
                            d.step[u] = q.step[u] + 4'h1;
                        end
                        if (done_w[u])
                        begin
                            d.result[u][q.chan[u][1:0]] = q.sar[u]; // RULE7
                            d.cnt[u] = 9'h000;
                            d.sar[u] = 10'h000;
                            d.step[u] = 4'h0;
                            if (last_w[u])
                            begin
                                d.csr[u][adcsq_pkg::CSR_END_FLAG_BIT] = 1'b1; // RULE4 RULE10
                            end
                            if (!q.csr[u][adcsq_pkg::CSR_SCAN_BIT])
                            begin
                                d.csr[u][adcsq_pkg::CSR_START_BIT] = 1'b0; // RULE3
                                d.phase[u] = adcsq_pkg::PH_IDLE;
                            end
                            else
                            begin
                                d.ch_idx[u] = last_w[u] ? 2'b00
                                              : q.ch_idx[u] + 2'b01; // RULE9 RULE10
                                d.sample[u] = 1'b1; // RULE14
                            end
                        end
                    end
                    default:
                    begin
                        d.phase[u] = adcsq_pkg::PH_IDLE;
                    end
                endcase
            end
            ch = d.csr[u][adcsq_pkg::CSR_SCAN_BIT] ? d.ch_idx[u]
                 : {d.csr[u][adcsq_pkg::CSR_CH_HI_BIT],
                    d.csr[u][adcsq_pkg::CSR_CH_LO_BIT]}; // RULE20
            d.chan[u] = {1'(u), ch};
            d.irq[u] = d.csr[u][adcsq_pkg::CSR_END_FLAG_BIT]
                       && d.csr[u][adcsq_pkg::CSR_IRQ_EN_BIT]; // RULE4
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            q <= '0;
            q.csr <= {adcsq_pkg::CSR_RESET, adcsq_pkg::CSR_RESET};
            q.trigger_enable <= {adcsq_pkg::TRG_EN_RESET, adcsq_pkg::TRG_EN_RESET};
            q.chan <= {3'h4, 3'h0};
            q.trig_pin_prev <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    assign bus_rdata_o = q.rdata;
    assign sample_o = q.sample;
    assign chan_o = q.chan;
    assign dac_code_o = q.sar;
    assign unit0_end_irq_o = q.irq[0];
    assign unit1_end_irq_o = q.irq[1];
    assign xfer_ctrl_req_o = q.irq[0]; // RULE17
    assign dma_req_o = q.irq[1]; // RULE17
endmodule

`default_nettype wire

/* File: tb/adcsq_analog_model.sv */
// Purpose: analog side of the sequencer: one fixed level per input and a comparator per unit
// Assumes: ideal comparator, so a correct search lands exactly on the level
// Notes: level of input c is 10'h0b5 + c * 10'h071, all within 10 bits
`timescale 1ns/10ps
`default_nettype none
module adcsq_analog_model (
    input wire logic [1:0][2:0] chan_i,
    input wire logic [1:0][9:0] dac_code_i,
    output logic [1:0] cmp_o
);
    function automatic logic [9:0] level(input logic [2:0] c);
        return 10'h0b5 + 10'(c) * 10'h071;
    endfunction
    // decision follows the trial code at once, the sequencer samples it a step later
    always_comb
    begin
        for (int u = 0; u < 2; u++)
        begin
            cmp_o[u] = level(chan_i[u]) >= dac_code_i[u];
        end
    end
endmodule
`default_nettype wire

/* File: tb/adc_conversion_sequencer_bench.sv */
// Purpose: self-checking bench of the two-unit conversion sequencer
// Assumes: byte register port, read data one cycle after the strobe
// Notes: expected codes come from the bench's own copy of the input levels
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fail_count++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
`define WAITFOR(c) begin n = 0; while (!(c) && n < 700) begin \
    @(posedge clk_sys_i); #1; n++; end `CHK(n < 700, 1'b1) end
module adc_conversion_sequencer_bench;
    logic clk_sys_i = 1'b0;
    logic srst_i = 1'b1;
    logic [4:0] bus_addr_i = 5'h00;
    logic [7:0] bus_wdata_i = 8'h00;
    logic bus_wr_i = 1'b0;
    logic bus_rd_i = 1'b0;
    logic xfer_ctrl_access_i = 1'b0;
    logic dma_access_i = 1'b0;
    logic ext_trigger_pin_n_i = 1'b1;
    logic timer_trigger_i = 1'b0;
    logic [7:0] bus_rdata_o;
    logic [1:0] cmp_i;
    logic [1:0] sample_o;
    logic [1:0][2:0] chan_o;
    logic [1:0][9:0] dac_code_o;
    logic unit0_end_irq_o, unit1_end_irq_o, xfer_ctrl_req_o, dma_req_o;
    logic [1:0] qual = 2'b00;
    logic [9:0] lv;
    logic seen;
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int n, t0, t1;

    always #5 clk_sys_i = ~clk_sys_i;

    adcsq_top DUT (.clk_sys_i, .srst_i, .bus_addr_i, .bus_wdata_i, .bus_wr_i, .bus_rd_i,
        .bus_rdata_o, .xfer_ctrl_access_i, .dma_access_i, .ext_trigger_pin_n_i,
        .timer_trigger_i, .cmp_i, .sample_o, .chan_o, .dac_code_o, .unit0_end_irq_o,
        .unit1_end_irq_o, .xfer_ctrl_req_o, .dma_req_o);
    adcsq_analog_model model (.chan_i(chan_o), .dac_code_i(dac_code_o), .cmp_o(cmp_i));

    function automatic logic [9:0] lvl(input int c);
        return 10'(10'h0b5 + c * 10'h071);
    endfunction

    task automatic end_of_test();
        $display("counts: %0d compares, %0d mismatches", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        bus_addr_i <= a;
        bus_wdata_i <= d;
        bus_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        bus_wr_i <= 1'b0;
    endtask

    // qual says which transfer engine makes the access: bit 0 transfer ctrl, bit 1 dma
    task automatic chk(input logic [4:0] a, input logic [7:0] e);
        @(posedge clk_sys_i);
        bus_addr_i <= a;
        bus_rd_i <= 1'b1;
        {dma_access_i, xfer_ctrl_access_i} <= qual;
        @(posedge clk_sys_i);
        bus_rd_i <= 1'b0;
        {dma_access_i, xfer_ctrl_access_i} <= 2'b00;
        #1;
        `CHK(bus_rdata_o, e)
    endtask

    task automatic quiet(input int u);
        seen = 1'b0;
        repeat (300)
        begin
            @(posedge clk_sys_i);
            #1 seen |= sample_o[u];
        end
    endtask

    always @(posedge clk_sys_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            end_of_test();
        end
    end

    initial
    begin
        repeat (10) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        chk(5'h08, 8'h02);
        chk(5'h18, 8'h02);
        chk(5'h09, 8'h7f);
        chk(5'h0a, 8'h00);
        $display("test reset_map done");

        wr(5'h08, 8'h61);
        #1 t0 = cyc;
        chk(5'h08, 8'h61);
        `WAITFOR(unit0_end_irq_o === 1'b1)
        `CHK((cyc - t0) inside {[259:266]}, 1'b1)
        `CHK({xfer_ctrl_req_o, dma_req_o}, 2'b10)
        wr(5'h08, 8'h41);
        chk(5'h08, 8'hc1);
        wr(5'h08, 8'h41);
        chk(5'h08, 8'h41);
        `CHK(unit0_end_irq_o, 1'b0)
        lv = lvl(1);
        chk(5'h02, lv[9:2]);
        chk(5'h03, {lv[1:0], 6'h00});
        $display("test single done");

        wr(5'h18, 8'h7a);
        #1 t0 = cyc;
        for (int k = 0; k < 4; k++)
        begin
            `WAITFOR(sample_o[1] === 1'b1)
            `CHK(chan_o[1], 3'(4 + k % 3))
            if (k == 0)
                `CHK((cyc - t0) inside {[6:9]}, 1'b1)
            else
                `CHK(cyc - t0, 128)
            t0 = cyc;
            `WAITFOR(sample_o[1] === 1'b0)
            @(posedge clk_sys_i);
            #1;
            `CHK(dac_code_o[1], 10'h200)
        end
        `CHK({xfer_ctrl_req_o, dma_req_o}, 2'b01)
        `CHK({unit0_end_irq_o, unit1_end_irq_o}, 2'b01)
        for (int c = 0; c < 3; c++)
        begin
            lv = lvl(4 + c);
            chk(5'(16 + 2 * c), lv[9:2]);
            chk(5'(17 + 2 * c), {lv[1:0], 6'h00});
        end
        qual = 2'b10;
        chk(5'h18, 8'hfa);
        qual = 2'b00;
        chk(5'h18, 8'h7a);
        wr(5'h18, 8'h5a);
        quiet(1);
        `CHK(seen, 1'b0)
        wr(5'h18, 8'h7a);
        `WAITFOR(sample_o[1] === 1'b1)
        `CHK(chan_o[1], 3'h4)
        wr(5'h18, 8'h5a);
        quiet(1);
        chk(5'h18, 8'h5a);
        $display("test scan done");

        wr(5'h09, 8'h80);
        chk(5'h09, 8'hff);
        wr(5'h08, 8'h42);
        @(posedge clk_sys_i);
        ext_trigger_pin_n_i <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        ext_trigger_pin_n_i <= 1'b1;
        chk(5'h08, 8'h62);
        chk(5'h18, 8'h7a);
        wr(5'h18, 8'h5a);
        `WAITFOR(unit0_end_irq_o === 1'b1)
        qual = 2'b01;
        chk(5'h08, 8'hc2);
        qual = 2'b00;
        chk(5'h08, 8'h42);
        lv = lvl(2);
        chk(5'h04, lv[9:2]);
        @(posedge clk_sys_i);
        timer_trigger_i <= 1'b1;
        @(posedge clk_sys_i);
        timer_trigger_i <= 1'b0;
        chk(5'h08, 8'h62);
        wr(5'h08, 8'h42);
        quiet(0);
        chk(5'h08, 8'h42);
        `CHK(unit0_end_irq_o, 1'b0)
        $display("test trigger done");
        end_of_test();
    end
endmodule
`default_nettype wire
